/* File: pwr_ctrl.sv */
// power-save controller: standby entry, wake qualification, wake response, clock gating
`include "pwr_defines.svh"
module pwr_ctrl #(
	parameter int N_EXT = 4, // external interrupt pins, bit 3 is pin three
	parameter int N_PER = 4  // peripheral requests alive in sleep
) (
	input  wire logic             clk_i,           // 25 MHz clock
	input  wire logic             rst_i,           // synchronous reset, high
	input  wire logic [3:0]       wb_adr_i,        // wishbone byte address
	input  wire logic [31:0]      wb_dat_i,        // wishbone write data
	input  wire logic [3:0]       wb_sel_i,        // wishbone byte selects
	input  wire logic             wb_we_i,         // wishbone write
	input  wire logic             wb_cyc_i,        // wishbone cycle
	input  wire logic             wb_stb_i,        // wishbone strobe
	output logic [31:0]           wb_dat_o,        // wishbone read data
	output logic                  wb_ack_o,        // wishbone ack
	input  wire logic             nmi_pin_i,       // nmi pin, async
	input  wire logic             watchdog_timeout_request_i, // watchdog nmi, async
	input  wire logic [N_EXT-1:0] ext_irq_i,       // external pins, async
	input  wire logic [N_PER-1:0] periph_irq_i,    // peripheral requests, async
	input  wire logic [N_EXT-1:0] ext_irq_mask_i,  // 1 masks pin request
	input  wire logic [N_PER-1:0] periph_mask_i,   // 1 masks peripheral request
	input  wire logic             pin3_filter_en_i,// noise filter on pin three
	input  wire logic             hi_osc_ready_i,  // 8 MHz oscillator set up, async
	input  wire logic             osc_ready_i,     // main osc/pll set up, async
	input  wire logic             halt_req_i,      // cpu halt instruction pulse
	input  wire logic             interrupts_enabled_state_i, // cpu interrupts on
	input  wire logic             in_service_i,    // service routine active
	input  wire logic [2:0]       in_service_prio_i, // level in service, 0 highest
	input  wire logic [2:0]       req_prio_i,      // level of waking request
	output logic                  wake_ack_o,      // acknowledge request, pulse
	output logic                  wake_vector_o,   // branch to handler, pulse
	output logic                  wake_continue_o, // next instruction, pulse
	output logic                  sub_mode_o,      // subclock operation
	output logic                  main_osc_clock_en_o,  // main oscillator
	output logic                  subclock_en_o,        // subclock oscillator
	output logic                  low_speed_internal_osc_clock_en_o,  // slow osc
	output logic                  high_speed_internal_osc_clock_en_o, // 8 MHz osc
	output logic                  pll_output_clock_en_o,   // pll
	output logic                  main_system_clock_en_o,  // system clock
	output logic                  peripheral_clock_en_o,   // peripheral clock
	output logic                  cpu_bus_clock_en_o,      // cpu bus clock
	output logic                  cpu_core_clock_en_o,     // cpu core clock
	output logic                  serial_timer_clock_en_o, // serial/timer clock
	output logic                  can_clock_en_o           // can clock
);
	localparam int NS = 4 + N_EXT + N_PER; // synchronised lines

	pwr_pkg::pwr_regs_t r_reg;   // registered state
	pwr_pkg::pwr_regs_t r_next;  // next state
	logic [NS-1:0]      raw;     // raw asynchronous lines
	logic [NS-1:0]      syn;     // synchronised lines
	logic               nmi_s;   // synced pin nmi
	logic               wdt_s;   // synced watchdog nmi
	logic               hi_rdy_s;// synced 8 MHz ready
	logic               osc_rdy_s; // synced main osc ready
	logic [N_EXT-1:0]   ext_s;   // synced pins
	logic [N_PER-1:0]   per_s;   // synced peripheral requests
	logic [N_EXT-1:0]   ext_ok;  // pins allowed to wake
	logic               nmi_wake;// qualified non-maskable wake
	logic               int_wake;// qualified maskable wake
	logic               wake;    // any qualified wake
	logic               access;  // new bus access this cycle

	assign raw = {periph_irq_i, ext_irq_i, osc_ready_i, hi_osc_ready_i,
		watchdog_timeout_request_i, nmi_pin_i};

	// every asynchronous line passes two flops before use
	wake_sync #(.WIDTH(NS)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (raw),
		.sync_o  (syn)
	);

	assign nmi_s     = syn[0];
	assign wdt_s     = syn[1];
	assign hi_rdy_s  = syn[2];
	assign osc_rdy_s = syn[3];
	assign ext_s     = syn[4 +: N_EXT];
	assign per_s     = syn[4 + N_EXT +: N_PER];

	// pin three is dropped from the wake set while its filter is on,
	// because the filter needs the clock that sleep has stopped
	always_comb begin
		ext_ok = ext_s & ~ext_irq_mask_i;
		if (pin3_filter_en_i && N_EXT > 3) begin
			ext_ok[3] = 1'b0;
		end
	end

	// qualification ignores priority; masks in the control register veto
	assign nmi_wake = (nmi_s & ~r_reg.nmi0_mask) | (wdt_s & ~r_reg.nmi1_mask);
	assign int_wake = ~r_reg.int_mask & ((|ext_ok) | (|(per_s & ~periph_mask_i)));
	assign wake     = nmi_wake | int_wake;

	// clock enable pattern of each state
	function automatic logic [10:0] gates_for(pwr_pkg::pwr_state_t st, logic pll);
		logic [10:0] g;
		g = `GATES_RESET;
		case (st)
			pwr_pkg::ST_RESET_SEQ:  g = `GATES_RESET_SEQ;
			pwr_pkg::ST_RUN_MAIN,
			pwr_pkg::ST_RUN_SUB:    g = `GATES_RUN;
			pwr_pkg::ST_HALT:       g = `GATES_HALT;
			pwr_pkg::ST_LIGHT_IDLE: g = `GATES_LIGHT;
			pwr_pkg::ST_DEEP_IDLE:  g = `GATES_DEEP;
			pwr_pkg::ST_STOP:       g = `GATES_STOP;
			pwr_pkg::ST_DEEP_SETUP: g = `GATES_SETUP;
			pwr_pkg::ST_SUB_SLEEP:  g = `GATES_SLEEP;
			default:                g = `GATES_RESET;
		endcase
		// pll only runs in run, halt, light idle and sub sleep, and only when the setting asks
		case (st)
			pwr_pkg::ST_RUN_MAIN, pwr_pkg::ST_RUN_SUB, pwr_pkg::ST_HALT,
			pwr_pkg::ST_LIGHT_IDLE, pwr_pkg::ST_SUB_SLEEP: g[`G_PLL] = pll;
			default:                g[`G_PLL] = 1'b0;
		endcase
		return g;
	endfunction : gates_for

	assign access = wb_cyc_i & wb_stb_i & ~r_reg.ack;

	// one combinational pass: bus, standby sequencing and wake response
	always_comb begin
		r_next         = r_reg;
		r_next.ack     = access;  // ack one cycle after the strobe, dropped next
		r_next.ack_irq = 1'b0;
		r_next.vector  = 1'b0;
		r_next.cont    = 1'b0;
		// register writes take effect on the edge that raises ack
		if (access && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				`OFS_CTRL: begin
					r_next.nmi0_mask = wb_dat_i[`CTRL_NMI0_MASK];
					r_next.nmi1_mask = wb_dat_i[`CTRL_NMI1_MASK];
					r_next.int_mask  = wb_dat_i[`CTRL_INT_MASK];
					r_next.pll_on    = wb_dat_i[`CTRL_PLL_ON];
					// subclock select; the reset sequence forces it back to main
					r_next.sub_mode  = wb_dat_i[`CTRL_SUB_SEL];
				end
				`OFS_MODE: r_next.mode_sel = wb_dat_i[1:0];
				default: begin
					// status, gates and unmapped offsets ignore writes
				end
			endcase
		end
		// read data, unmapped offsets read zero
		r_next.dat = '0;
		if (access && !wb_we_i) begin
			case (wb_adr_i)
				`OFS_CTRL:   r_next.dat[5:0] = {r_reg.sub_mode, r_reg.pll_on, 1'b0, r_reg.int_mask,
					r_reg.nmi1_mask, r_reg.nmi0_mask};
				`OFS_MODE:   r_next.dat[1:0] = r_reg.mode_sel;
				`OFS_STATUS: r_next.dat[11:0] = {r_reg.cause, r_reg.sub_mode, r_reg.state};
				`OFS_GATES:  r_next.dat[10:0] = r_reg.gates;
				default:     r_next.dat = '0;
			endcase
		end
		case (r_reg.state)
			pwr_pkg::ST_RESET_SEQ: begin
				// reset always lands in normal mode on the main clock
				r_next.sub_mode = 1'b0;
				if (hi_rdy_s) begin
					r_next.state = pwr_pkg::ST_RUN_MAIN;
				end
			end
			pwr_pkg::ST_RUN_MAIN, pwr_pkg::ST_RUN_SUB: begin
				if (access && wb_we_i && wb_sel_i[0] && wb_adr_i == `OFS_CTRL &&
						wb_dat_i[`CTRL_TRIGGER]) begin
					// trigger is self-clearing; it starts the selected standby mode, sub sleep only while on the subclock
					case (r_next.mode_sel)
						`MODE_SUB_SLEEP: begin
							if (r_reg.sub_mode) begin
								r_next.state     = pwr_pkg::ST_SUB_SLEEP;
								r_next.pll_saved = r_next.pll_on;
							end
						end
						`MODE_LIGHT_IDLE: r_next.state = pwr_pkg::ST_LIGHT_IDLE;
						`MODE_STOP:       r_next.state = pwr_pkg::ST_STOP;
						`MODE_DEEP_IDLE:  r_next.state = pwr_pkg::ST_DEEP_IDLE;
						default:          r_next.state = r_reg.state;
					endcase
				end else if (halt_req_i) begin
					r_next.state = pwr_pkg::ST_HALT;
				end else begin
					// the run state follows the software clock select
					r_next.state = r_next.sub_mode ? pwr_pkg::ST_RUN_SUB : pwr_pkg::ST_RUN_MAIN;
				end
			end
			pwr_pkg::ST_HALT, pwr_pkg::ST_LIGHT_IDLE: begin
				if (wake) begin
					r_next.state = r_reg.sub_mode ? pwr_pkg::ST_RUN_SUB : pwr_pkg::ST_RUN_MAIN;
				end
			end
			pwr_pkg::ST_DEEP_IDLE, pwr_pkg::ST_STOP: begin
				// oscillators and pll must settle before derived clocks return
				if (wake) begin
					r_next.state = pwr_pkg::ST_DEEP_SETUP;
				end
			end
			pwr_pkg::ST_DEEP_SETUP: begin
				if (osc_rdy_s) begin
					r_next.state = r_reg.sub_mode ? pwr_pkg::ST_RUN_SUB : pwr_pkg::ST_RUN_MAIN;
				end
			end
			pwr_pkg::ST_SUB_SLEEP: begin
				if (wake) begin
					r_next.state  = pwr_pkg::ST_RUN_SUB;
					r_next.pll_on = r_reg.pll_saved;
				end
			end
			default: r_next.state = pwr_pkg::ST_RESET_SEQ;
		endcase
		// wake response, shared by every standby state
		// only a standby exit answers: leaving setup or the reset sequence with a
		// line still high must not answer a second time
		if (wake && r_reg.state != r_next.state &&
				r_reg.state inside {pwr_pkg::ST_HALT, pwr_pkg::ST_LIGHT_IDLE,
					pwr_pkg::ST_DEEP_IDLE, pwr_pkg::ST_STOP, pwr_pkg::ST_SUB_SLEEP}) begin
			if (nmi_wake) begin
				// non-maskable outranks any routine in service
				r_next.vector  = 1'b1;
				r_next.ack_irq = 1'b1;
				r_next.cause   = 2'h1;
			end else begin
				r_next.cause = 2'h2;
				if (!interrupts_enabled_state_i) begin
					r_next.cont = 1'b1;
				end else if (in_service_i && req_prio_i >= in_service_prio_i) begin
					// lower or equal level: woken, left pending in the controller
					r_next.cont = 1'b1;
				end else begin
					r_next.vector  = 1'b1;
					r_next.ack_irq = 1'b1;
				end
			end
		end
		r_next.gates = gates_for(r_next.state, r_next.pll_on);
	end

	// single register for the whole state; reset reruns the ordinary sequence
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '{state: pwr_pkg::ST_RESET_SEQ, gates: `GATES_RESET,
				default: '0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign wb_dat_o        = r_reg.dat;
	assign wb_ack_o        = r_reg.ack;
	assign wake_ack_o      = r_reg.ack_irq;
	assign wake_vector_o   = r_reg.vector;
	assign wake_continue_o = r_reg.cont;
	assign sub_mode_o      = r_reg.sub_mode;
	assign main_osc_clock_en_o                = r_reg.gates[`G_MAIN_OSC];
	assign subclock_en_o                      = r_reg.gates[`G_SUB];
	assign low_speed_internal_osc_clock_en_o  = r_reg.gates[`G_LO_OSC];
	assign high_speed_internal_osc_clock_en_o = r_reg.gates[`G_HI_OSC];
	assign pll_output_clock_en_o              = r_reg.gates[`G_PLL];
	assign main_system_clock_en_o             = r_reg.gates[`G_SYS];
	assign peripheral_clock_en_o              = r_reg.gates[`G_PERIPH];
	assign cpu_bus_clock_en_o                 = r_reg.gates[`G_BUS];
	assign cpu_core_clock_en_o                = r_reg.gates[`G_CORE];
	assign serial_timer_clock_en_o            = r_reg.gates[`G_SERIAL];
	assign can_clock_en_o                     = r_reg.gates[`G_CAN];

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic in_sleep; // helper: sleeping this cycle
	assign in_sleep = r_reg.state == pwr_pkg::ST_SUB_SLEEP;

	sequence sleep_wake_s;
		in_sleep && wake;
	endsequence
	sequence sleep_nmi_s;
		in_sleep && nmi_wake;
	endsequence

	sleep_exit_sub_a: assert property (sleep_wake_s |=> r_reg.state == pwr_pkg::ST_RUN_SUB)
		else $error("sleep wake did not resume subclock operation");
	pll_restore_a: assert property (sleep_wake_s |=> r_reg.pll_on == $past(r_reg.pll_saved))
		else $error("pll setting not restored on wake");
	mask_holds_a: assert property (in_sleep && !wake && !access |=> in_sleep)
		else $error("sleep left without a qualified wake");
	pin3_filter_a: assert property (pin3_filter_en_i |-> !ext_ok[N_EXT > 3 ? 3 : 0] ||
		N_EXT <= 3)
		else $error("filtered pin three allowed to wake");
	nmi_vector_a: assert property (sleep_nmi_s |=> wake_vector_o && wake_ack_o
		##1 !wake_vector_o)
		else $error("nmi wake did not branch once");
	di_continue_a: assert property (sleep_wake_s ##0 !nmi_wake && !interrupts_enabled_state_i
		|=> wake_continue_o && !wake_vector_o && !wake_ack_o)
		else $error("maskable wake with interrupts off did not continue");
	low_prio_a: assert property (sleep_wake_s ##0 !nmi_wake && interrupts_enabled_state_i &&
		in_service_i && req_prio_i >= in_service_prio_i |=> !wake_ack_o && wake_continue_o)
		else $error("lower priority request acknowledged");
	reset_seq_a: assert property (disable iff (1'b0) rst_i ##1 !rst_i |->
		r_reg.state == pwr_pkg::ST_RESET_SEQ && !sub_mode_o)
		else $error("reset did not start the normal sequence");
	reset_gates_a: assert property (r_reg.state == pwr_pkg::ST_RESET_SEQ && !$past(rst_i) |->
		r_reg.gates == `GATES_RESET_SEQ && !cpu_core_clock_en_o)
		else $error("wrong clocks during reset setup");
	halt_gate_a: assert property (r_reg.state == pwr_pkg::ST_HALT |->
		!cpu_core_clock_en_o && main_system_clock_en_o && peripheral_clock_en_o)
		else $error("halt gating wrong");
	setup_gate_a: assert property (r_reg.state == pwr_pkg::ST_DEEP_SETUP |->
		main_osc_clock_en_o && subclock_en_o && !pll_output_clock_en_o &&
		!main_system_clock_en_o && !can_clock_en_o)
		else $error("deep idle setup gating wrong");
	wake_now_a: assert property (r_reg.state inside {pwr_pkg::ST_HALT, pwr_pkg::ST_LIGHT_IDLE}
		&& wake |=> r_reg.state inside {pwr_pkg::ST_RUN_SUB, pwr_pkg::ST_RUN_MAIN})
		else $error("qualified wake ignored");
	sync_wake_a: assert property (in_sleep && !wake |=>
		!wake_vector_o && !wake_ack_o && !wake_continue_o)
		else $error("wake response without synced request");
endmodule : pwr_ctrl

/* File: pwr_defines.svh */
// offsets, field positions, reset values and clock gate patterns of the power-save controller
// Functional notes
// - wake on nmi, unmasked irq or reset
// - pll restored to pre-sleep state on exit
// - interrupt wake resumes subclock operation
// - reset wake resumes normal operation
// - masked sources never wake the device
// - filtered pin three cannot wake
// - wake ignores priority level
// - lower priority wakes, stays pending, unacknowledged
// - higher priority wakes and is acknowledged
// - nmi wake always branches to handler
// - maskable wake branches only when enabled
// - reset wake runs ordinary reset sequence
// - reset setup: subclock, internal oscs, system
// - deep idle setup: oscillators only
// - per-standby clock gating pattern
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH
// register byte offsets
`define OFS_CTRL        4'h0
`define OFS_MODE        4'h4
`define OFS_STATUS      4'h8
`define OFS_GATES       4'hC
// control register fields
`define CTRL_NMI0_MASK  0
`define CTRL_NMI1_MASK  1
`define CTRL_INT_MASK   2
`define CTRL_TRIGGER    3
`define CTRL_PLL_ON     4
`define CTRL_SUB_SEL    5
// mode select codes
`define MODE_LIGHT_IDLE 2'h0
`define MODE_STOP       2'h1
`define MODE_SUB_SLEEP  2'h2
`define MODE_DEEP_IDLE  2'h3
// clock gate vector bit positions
`define G_MAIN_OSC      10
`define G_SUB           9
`define G_LO_OSC        8
`define G_HI_OSC        7
`define G_PLL           6
`define G_SYS           5
`define G_PERIPH        4
`define G_BUS           3
`define G_CORE          2
`define G_SERIAL        1
`define G_CAN           0
// gate patterns, pll bit left clear and filled in from the pll setting in run, halt, light idle and sub sleep
`define GATES_RESET     11'h200
`define GATES_RESET_SEQ 11'h3A0
`define GATES_RUN       11'h7BF
`define GATES_HALT      11'h7BB
`define GATES_LIGHT     11'h782
`define GATES_DEEP      11'h780
`define GATES_STOP      11'h380
`define GATES_SETUP     11'h780
`define GATES_SLEEP     11'h780
`endif

/* File: pwr_pkg.sv */
// types shared by the power-save controller
package pwr_pkg;
	// one-hot controller states
	typedef enum logic [8:0] {
		ST_RESET_SEQ  = 9'h001,
		ST_RUN_MAIN   = 9'h002,
		ST_RUN_SUB    = 9'h004,
		ST_HALT       = 9'h008,
		ST_LIGHT_IDLE = 9'h010,
		ST_DEEP_IDLE  = 9'h020,
		ST_DEEP_SETUP = 9'h040,
		ST_STOP       = 9'h080,
		ST_SUB_SLEEP  = 9'h100
	} pwr_state_t;

	// complete state of the controller
	typedef struct packed {
		pwr_state_t  state;      // controller state
		logic        ack;        // wishbone ack
		logic [31:0] dat;        // wishbone read data
		logic        nmi0_mask;  // blocks pin nmi wake
		logic        nmi1_mask;  // blocks watchdog wake
		logic        int_mask;   // blocks maskable wake
		logic        pll_on;     // pll run setting
		logic        pll_saved;  // pll setting at sleep entry
		logic [1:0]  mode_sel;   // standby mode select
		logic        sub_mode;   // running on subclock
		logic [10:0] gates;      // clock enables
		logic        ack_irq;    // acknowledge pulse
		logic        vector;     // branch pulse
		logic        cont;       // continue pulse
		logic [1:0]  cause;      // last wake cause
	} pwr_regs_t;
endpackage : pwr_pkg

/* File: wake_sync.sv */
// two-flop synchroniser bank for asynchronous wake lines
module wake_sync #(
	parameter int WIDTH = 4   // number of lines
) (
	input  wire logic             clk_i,   // controller clock
	input  wire logic             rst_i,   // synchronous reset, high
	input  wire logic [WIDTH-1:0] async_i, // raw lines
	output logic      [WIDTH-1:0] sync_o   // synchronised lines
);
	logic [WIDTH-1:0] meta_reg; // first stage, read only by second
	logic [WIDTH-1:0] sync_reg; // second stage

	// both stages clear under reset; the first stage feeds nothing else
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;
endmodule : wake_sync

/* File: cpu_side_model.sv */
// cpu core and interrupt controller stand-in facing the power-save controller
module cpu_side_model (
	input  wire logic       clk_i,                      // controller clock
	input  wire logic       rst_i,                      // synchronous reset, high
	input  wire logic       halt_cmd_i,                 // bench asks for one halt instruction
	input  wire logic       ei_cmd_i,                   // bench interrupt enable setting
	input  wire logic [2:0] svc_cmd_i,                  // bench level in service, 7 means none
	input  wire logic [2:0] req_cmd_i,                  // bench level of the next request
	input  wire logic       wake_ack_i,                 // acknowledge pulse from controller
	input  wire logic       wake_continue_i,            // continue pulse from controller
	output logic            halt_req_o,                 // halt instruction pulse
	output logic            interrupts_enabled_state_o, // interrupts on
	output logic            in_service_o,               // service routine active
	output logic [2:0]      in_service_prio_o,          // level in service
	output logic [2:0]      req_prio_o,                 // level of the waking request
	output logic            pending_o                   // request held without acknowledge
);
	// cpu levels change only after an edge, like a real core retiring instructions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_req_o                 <= 1'b0;
			interrupts_enabled_state_o <= 1'b0;
			in_service_o               <= 1'b0;
			in_service_prio_o          <= 3'h7;
			req_prio_o                 <= 3'h7;
			pending_o                  <= 1'b0;
		end else begin
			halt_req_o                 <= halt_cmd_i;
			interrupts_enabled_state_o <= ei_cmd_i;
			in_service_o               <= (svc_cmd_i != 3'h7);
			in_service_prio_o          <= svc_cmd_i;
			req_prio_o                 <= req_cmd_i;
			// a continue pulse while a routine is in service leaves the request held until acknowledged
			if (wake_ack_i)
				pending_o <= 1'b0;
			else if (wake_continue_i && in_service_o)
				pending_o <= 1'b1;
		end
	end
endmodule : cpu_side_model

/* File: pwr_ctrl_tb.sv */
// self-checking bench of the power-save controller
`include "pwr_defines.svh"
module pwr_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0; // bus and clock
	logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;    // bus address and selects
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rnd;     // bus data, random state
	logic        wb_ack_o, nmi_pin_i = 0, wdt_i = 0;  // ack and non-maskable lines
	logic [3:0]  ext_irq_i = 4'h0, periph_irq_i = 4'h0, ext_mask_i = 4'h0, per_mask_i = 4'h0;
	logic        filt_i = 0, hi_rdy_i = 0, osc_rdy_i = 0, halt_cmd = 0, ei_cmd = 0; // controls
	logic [2:0]  svc_cmd = 3'h7, req_cmd = 3'h7;      // cpu levels for the model
	logic        halt_w, ei_w, svc_w, pend_w, ack_w, vec_w, cont_w, sub_w; // cpu side nets
	logic [2:0]  svc_prio_w, req_prio_w;               // priority levels
	wire  [10:0] gate_pins;                            // clock enables in register order
	logic [31:0] exp_rd[$];                            // expected read data
	logic [2:0]  exp_rsp[$];                           // expected {ack, vector, continue}
	int          fail_count = 0, cmp_count = 0, cyc_n = 0; // counters
	always #20 clk_i = ~clk_i;                          // 25 MHz
	pwr_ctrl pwr_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_pin_i(nmi_pin_i),
		.watchdog_timeout_request_i(wdt_i), .ext_irq_i(ext_irq_i), .periph_irq_i(periph_irq_i),
		.ext_irq_mask_i(ext_mask_i), .periph_mask_i(per_mask_i), .pin3_filter_en_i(filt_i),
		.hi_osc_ready_i(hi_rdy_i), .osc_ready_i(osc_rdy_i), .halt_req_i(halt_w),
		.interrupts_enabled_state_i(ei_w), .in_service_i(svc_w), .in_service_prio_i(svc_prio_w),
		.req_prio_i(req_prio_w), .wake_ack_o(ack_w), .wake_vector_o(vec_w),
		.wake_continue_o(cont_w), .sub_mode_o(sub_w),
		.main_osc_clock_en_o(gate_pins[10]), .subclock_en_o(gate_pins[9]),
		.low_speed_internal_osc_clock_en_o(gate_pins[8]),
		.high_speed_internal_osc_clock_en_o(gate_pins[7]), .pll_output_clock_en_o(gate_pins[6]),
		.main_system_clock_en_o(gate_pins[5]), .peripheral_clock_en_o(gate_pins[4]),
		.cpu_bus_clock_en_o(gate_pins[3]), .cpu_core_clock_en_o(gate_pins[2]),
		.serial_timer_clock_en_o(gate_pins[1]), .can_clock_en_o(gate_pins[0]));
	cpu_side_model cpu_side_model_i (.clk_i(clk_i), .rst_i(rst_i), .halt_cmd_i(halt_cmd),
		.ei_cmd_i(ei_cmd), .svc_cmd_i(svc_cmd), .req_cmd_i(req_cmd), .wake_ack_i(ack_w),
		.wake_continue_i(cont_w), .halt_req_o(halt_w), .interrupts_enabled_state_o(ei_w),
		.in_service_o(svc_w), .in_service_prio_o(svc_prio_w), .req_prio_o(req_prio_w),
		.pending_o(pend_w));
	// galois feedback register, fixed seed for repeatable runs
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr
	task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t read exp %h got %h", $time, exp, got);
		end
	endtask : cmp_rd
	task automatic cmp_rsp(input logic [2:0] exp, input logic [2:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t wake exp %h got %h", $time, exp, got);
		end
	endtask : cmp_rsp
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// classic single cycle, held until ack is sampled high at an edge
	task automatic wb(input logic we, input logic [3:0] sel, input logic [3:0] adr,
		input logic [31:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= sel;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : wb
	task automatic rd_exp(input logic [3:0] adr, input logic [31:0] exp);
		exp_rd.push_back(exp);
		wb(1'b0, 4'hF, adr, 32'h0);
	endtask : rd_exp
	task automatic chk_gates(input logic [10:0] exp);
		cmp_rd({21'h0, exp}, {21'h0, gate_pins});
		rd_exp(4'hC, {21'h0, exp});
	endtask : chk_gates
	// raise one wake line; exp 0 means the line must not wake the block
	task automatic wake_by(input int src, input logic [2:0] exp);
		if (exp !== 3'h0) exp_rsp.push_back(exp);
		case (src)
			0: nmi_pin_i <= 1'b1;
			1: wdt_i <= 1'b1;
			2: ext_irq_i <= 4'h1;
			3: ext_irq_i <= 4'h8;
			default: periph_irq_i <= 4'h1;
		endcase
		repeat (12) @(posedge clk_i);
		if (exp_rsp.size() != 0) cmp_rsp(exp_rsp.pop_front(), 3'h0);
		{nmi_pin_i, wdt_i, ext_irq_i, periph_irq_i} <= 10'h0;
		repeat (6) @(posedge clk_i);
	endtask : wake_by
	task automatic halt();
		@(posedge clk_i) halt_cmd <= 1'b1;
		@(posedge clk_i) halt_cmd <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask : halt
	// monitor: each result takes the oldest note off its queue
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			fail_count++;
			end_sim();
		end
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
			cmp_rd(exp_rd.size() != 0 ? exp_rd.pop_front() : 32'hDEADBEEF, wb_dat_o);
		if ({ack_w, vec_w, cont_w} !== 3'h0)
			cmp_rsp(exp_rsp.size() != 0 ? exp_rsp.pop_front() : 3'h0, {ack_w, vec_w, cont_w});
	end
	// main sequence
	initial begin
		rnd = 32'h6BF12E86;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_gates(`GATES_RESET_SEQ);
		rd_exp(4'h8, 32'h1);
		hi_rdy_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		rd_exp(4'h8, 32'h2);
		rd_exp(4'h0, 32'h0);
		rd_exp(4'h4, 32'h0);
		rd_exp(4'h2, 32'h0);
		wb(1'b1, 4'hF, 4'h8, 32'hFFFFFFFF);
		wb(1'b1, 4'hE, 4'h0, 32'h7);
		rd_exp(4'h8, 32'h2);
		rd_exp(4'h0, 32'h0);
		// random mask and mode values, trigger kept clear so nothing enters standby
		repeat (3) begin
			rnd = lfsr(rnd);
			wb(1'b1, 4'hF, 4'h0, rnd & 32'h17);
			rd_exp(4'h0, rnd & 32'h17);
			wb(1'b1, 4'hF, 4'h4, rnd);
			rd_exp(4'h4, rnd & 32'h3);
		end
		wb(1'b1, 4'hF, 4'h0, 32'h0);
		chk_gates(`GATES_RUN);
		halt();
		chk_gates(`GATES_HALT);
		wake_by(0, 3'h6);
		chk_gates(`GATES_RUN);
		wb(1'b1, 4'hF, 4'h0, 32'h1);
		halt();
		wake_by(0, 3'h0);
		wake_by(4, 3'h1);
		wb(1'b1, 4'hF, 4'h0, 32'h4);
		halt();
		wake_by(4, 3'h0);
		wake_by(1, 3'h6);
		wb(1'b1, 4'hF, 4'h4, 32'h0);
		wb(1'b1, 4'hF, 4'h0, 32'h8);
		chk_gates(`GATES_LIGHT);
		filt_i <= 1'b1;
		ei_cmd <= 1'b1;
		svc_cmd <= 3'h2;
		req_cmd <= 3'h5;
		wake_by(3, 3'h0);
		rd_exp(4'h8, 32'h410);
		wake_by(2, 3'h1);
		cmp_rsp(3'h1, {2'b0, pend_w});
		chk_gates(`GATES_RUN);
		filt_i <= 1'b0;
		wb(1'b1, 4'hF, 4'h4, 32'h3);
		wb(1'b1, 4'hF, 4'h0, 32'h18);
		chk_gates(`GATES_DEEP);
		svc_cmd <= 3'h4;
		req_cmd <= 3'h1;
		wake_by(4, 3'h6);
		cmp_rsp(3'h0, {2'b0, pend_w});
		chk_gates(`GATES_SETUP);
		osc_rdy_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk_gates(`GATES_RUN | 11'h040);
		osc_rdy_i <= 1'b0;
		ei_cmd <= 1'b0;
		wb(1'b1, 4'hF, 4'h4, 32'h1);
		wb(1'b1, 4'hF, 4'h0, 32'h8);
		chk_gates(`GATES_STOP);
		wake_by(1, 3'h6);
		chk_gates(`GATES_SETUP);
		osc_rdy_i <= 1'b1;
		hi_rdy_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		// subclock operation, sleep with the pll running, pll dropped while asleep
		wb(1'b1, 4'hF, 4'h0, 32'h30);
		rd_exp(4'h8, 32'h604);
		wb(1'b1, 4'hF, 4'h4, 32'h2);
		wb(1'b1, 4'hF, 4'h0, 32'h38);
		chk_gates(`GATES_SLEEP | 11'h040);
		wb(1'b1, 4'hF, 4'h0, 32'h20);
		chk_gates(`GATES_SLEEP);
		wake_by(2, 3'h1);
		chk_gates(`GATES_RUN | 11'h040);
		rd_exp(4'h8, 32'hA04);
		ei_cmd <= 1'b1;
		svc_cmd <= 3'h2;
		req_cmd <= 3'h5;
		wb(1'b1, 4'hF, 4'h0, 32'h28);
		wake_by(4, 3'h1);
		wb(1'b1, 4'hF, 4'h0, 32'h28);
		wake_by(0, 3'h6);
		rst_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk_gates(`GATES_RESET_SEQ);
		rd_exp(4'h0, 32'h0);
		rd_exp(4'h8, 32'h1);
		end_sim();
	end
endmodule : pwr_ctrl_tb
